//--- logic/psq_host.v
`timescale 1ns/100ps
// Function
// - after select rises, output enable held unchanged 10 ns before change.
// - after select rises, write enable held unchanged 10 ns before change.
// - power-up keeps the keep enable low at least 50 us.
// - select stays high 300 us after keep enable rises at power-up.
// - a power-down entry and exit may serve as a reset.
// - programming issues six accesses, all address high in cycles 1-5.
// - with select and output enable low, a byte lane is enabled.
// - select-controlled writes may keep output enable low.
// - select may stay low for output/write enable controlled accesses.
// - power-down holds keep enable low at least 65 ns.
// - partial-mode exit keeps select high 1 us after keep enable rises.
`include "psq_map.vh"
module psq_host #(
  parameter AW = 22,
  parameter DW = 16,
  parameter KEEP_LOW_CYC = `PSQ_PWRUP_KEEP_LOW_CYC,
  parameter SEL_HIGH_CYC = `PSQ_PWRUP_SEL_HIGH_CYC,
  parameter PART_EXIT_CYC = `PSQ_PART_EXIT_SEL_CYC,
  parameter PARTIAL_MODE = 0
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // command port
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire [AW-1:0] cmd_addr,
  input wire [DW-1:0] cmd_wdata,
  input wire [1:0] cmd_lanes_n,
  output reg cmd_ready,
  output reg rsp_valid,
  output reg [DW-1:0] rsp_rdata,
  output reg init_done,
  // memory pins
  output reg chip_select_n,
  output reg power_keep_enable,
  output reg output_enable_n,
  output reg write_enable_n,
  output reg lower_byte_lane_n,
  output reg upper_byte_lane_n,
  output reg [AW-1:0] mem_addr,
  output reg [DW-1:0] mem_dq_o,
  output reg mem_dq_oe,
  input wire [DW-1:0] mem_dq_i
);
  localparam [9:0] S_PU_LOW = 10'h001;
  localparam [9:0] S_PU_HIGH = 10'h002;
  localparam [9:0] S_IDLE = 10'h004;
  localparam [9:0] S_ACC = 10'h008;
  localparam [9:0] S_DESEL = 10'h010;
  localparam [9:0] S_PDN = 10'h020;
  localparam [9:0] S_PEXIT = 10'h040;
  localparam [9:0] S_PROG = 10'h080;
  localparam [9:0] S_PGAP = 10'h100;
  localparam [9:0] S_PEND = 10'h200;
  localparam TW = 32;
  localparam [TW-1:0] ACC_C = `PSQ_ACCESS_CYC;
  localparam [TW-1:0] HOLD_C = `PSQ_DESEL_HOLD_CYC;
  localparam [TW-1:0] PDN_C = `PSQ_PDN_KEEP_LOW_CYC;
  localparam [TW-1:0] CP_C = `PSQ_SEL_HIGH_CYC;
  localparam [TW-1:0] KL_C = KEEP_LOW_CYC;
  localparam [TW-1:0] SH_C = SEL_HIGH_CYC;
  localparam [TW-1:0] PE_C = PART_EXIT_CYC;

  reg [9:0] state_r;
  reg [1:0] op_r;
  reg [2:0] prog_n_r;
  reg [AW-1:0] key_r;
  reg [DW-1:0] dq_s1_r, dq_s2_r, dq_s3_r;
  reg tload;
  reg [TW-1:0] tval;
  wire tdone;

  psq_timer #(.W(TW)) u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(tload),
    .value(tval),
    .done(tdone)
  );

  // ----------------------------------------
  // read data sync; value is read only once the bus settled
  // ----------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_s1_r <= {DW{1'b0}};
      dq_s2_r <= {DW{1'b0}};
      dq_s3_r <= {DW{1'b0}};
    end else begin
      dq_s1_r <= mem_dq_i;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
    end
  end

  always @* begin
    tload = 1'b0;
    tval = {TW{1'b0}};
    case (state_r)
      S_IDLE: begin
        if (cmd_valid) begin
          tload = 1'b1;
          tval = (cmd_op == `PSQ_CMD_PDN) ? PDN_C : ACC_C;
        end
      end
      S_ACC, S_PROG: begin
        if (tdone) begin
          tload = 1'b1;
          tval = (state_r == S_PROG) ? CP_C : HOLD_C;
        end
      end
      S_PU_LOW: begin
        if (tdone) begin
          tload = 1'b1;
          tval = (op_r == 2'h3) ? SH_C : KL_C;
        end
      end
      S_PDN: begin
        if (tdone) begin
          tload = 1'b1;
          // sleep exit acts as a reset: full select hold as at power-up, partial-exit hold with PARTIAL_MODE
          tval = (PARTIAL_MODE != 0) ? PE_C : SH_C;
        end
      end
      S_PGAP: begin
        if (tdone) begin
          tload = 1'b1;
          tval = ACC_C;
        end
      end
      default: begin
        tload = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= S_PU_LOW;
      op_r <= 2'h0;
      prog_n_r <= 3'h0;
      key_r <= {AW{1'b0}};
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DW{1'b0}};
      init_done <= 1'b0;
      chip_select_n <= 1'b1;
      power_keep_enable <= 1'b0;
      output_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      lower_byte_lane_n <= 1'b1;
      upper_byte_lane_n <= 1'b1;
      mem_addr <= {AW{1'b0}};
      mem_dq_o <= {DW{1'b0}};
      mem_dq_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_r)
        S_PU_LOW: begin
          // timer is zero out of reset: first pass loads the low hold
          if (tdone) begin
            if (op_r == 2'h3) begin
              power_keep_enable <= 1'b1;
              state_r <= S_PU_HIGH;
            end else begin
              op_r <= 2'h3;
            end
          end
        end
        S_PU_HIGH: begin
          if (tdone) begin
            init_done <= 1'b1;
            cmd_ready <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (cmd_valid) begin
            cmd_ready <= 1'b0;
            op_r <= cmd_op;
            key_r <= cmd_addr;
            case (cmd_op)
              `PSQ_CMD_PDN: begin
                power_keep_enable <= 1'b0;
                state_r <= S_PDN;
              end
              `PSQ_CMD_PROG: begin
                // all-ones address for cycles 1-5, key on cycle 6
                prog_n_r <= 3'h1;
                mem_addr <= {AW{1'b1}};
                chip_select_n <= 1'b0;
                output_enable_n <= 1'b0;
                lower_byte_lane_n <= 1'b0;
                upper_byte_lane_n <= 1'b0;
                state_r <= S_PROG;
              end
              default: begin
                mem_addr <= cmd_addr;
                // select framed per access, never tied low
                chip_select_n <= 1'b0;
                upper_byte_lane_n <= cmd_lanes_n[1];
                if (cmd_op == `PSQ_CMD_WRITE) begin
                  // oe kept high on writes; a masked write touches no byte
                  output_enable_n <= 1'b1;
                  lower_byte_lane_n <= cmd_lanes_n[0];
                  write_enable_n <= 1'b0;
                  mem_dq_o <= cmd_wdata;
                  mem_dq_oe <= 1'b1;
                end else begin
                  // never both lanes off with a read pending
                  lower_byte_lane_n <= cmd_lanes_n[0] & cmd_lanes_n[1] ? 1'b0 : cmd_lanes_n[0];
                  output_enable_n <= 1'b0;
                end
                state_r <= S_ACC;
              end
            endcase
          end
        end
        S_ACC: begin
          if (tdone) begin
            if (op_r == `PSQ_CMD_READ) begin
              rsp_rdata <= dq_s3_r;
              rsp_valid <= 1'b1;
            end
            // select rises alone; oe/we wait out the hold
            chip_select_n <= 1'b1;
            state_r <= S_DESEL;
          end
        end
        S_DESEL: begin
          if (tdone) begin
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            lower_byte_lane_n <= 1'b1;
            upper_byte_lane_n <= 1'b1;
            mem_dq_oe <= 1'b0;
            cmd_ready <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_PDN: begin
          if (tdone) begin
            power_keep_enable <= 1'b1;
            state_r <= S_PEXIT;
          end
        end
        S_PEXIT: begin
          // select held high after exit, shorter with partial mode
          if (tdone) begin
            cmd_ready <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_PROG: begin
          if (tdone) begin
            chip_select_n <= 1'b1;
            state_r <= (prog_n_r == `PSQ_PROG_CYCLES) ? S_PEND : S_PGAP;
          end
        end
        S_PGAP: begin
          if (tdone) begin
            prog_n_r <= prog_n_r + 3'h1;
            chip_select_n <= 1'b0;
            // key format is the caller's duty; device guarantees nothing otherwise
            if (prog_n_r == 3'h5) begin
              mem_addr <= key_r;
              output_enable_n <= 1'b1;
              write_enable_n <= 1'b0;
            end
            state_r <= S_PROG;
          end
        end
        S_PEND: begin
          if (tdone) begin
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            lower_byte_lane_n <= 1'b1;
            upper_byte_lane_n <= 1'b1;
            cmd_ready <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_PU_LOW;
        end
      endcase
    end
  end
endmodule

//--- logic/psq_map.vh
`ifndef PSQ_MAP_VH
`define PSQ_MAP_VH
// ----------------------------------------
// timing figures, printed units
// ----------------------------------------
`define PSQ_CLK_MHZ 100
`define PSQ_DESEL_HOLD_NS 10
`define PSQ_PWRUP_KEEP_LOW_US 50
`define PSQ_PWRUP_SEL_HIGH_US 300
`define PSQ_PDN_KEEP_LOW_NS 65
`define PSQ_PART_EXIT_SEL_US 1
`define PSQ_SEL_HIGH_NS 12
`define PSQ_ACCESS_NS 70
// ----------------------------------------
// derived cycle counts (least times round up)
// ----------------------------------------
`define PSQ_DESEL_HOLD_CYC ((`PSQ_DESEL_HOLD_NS * `PSQ_CLK_MHZ + 999) / 1000)
`define PSQ_PWRUP_KEEP_LOW_CYC (`PSQ_PWRUP_KEEP_LOW_US * `PSQ_CLK_MHZ)
`define PSQ_PWRUP_SEL_HIGH_CYC (`PSQ_PWRUP_SEL_HIGH_US * `PSQ_CLK_MHZ)
`define PSQ_PDN_KEEP_LOW_CYC ((`PSQ_PDN_KEEP_LOW_NS * `PSQ_CLK_MHZ + 999) / 1000)
`define PSQ_PART_EXIT_SEL_CYC (`PSQ_PART_EXIT_SEL_US * `PSQ_CLK_MHZ)
`define PSQ_SEL_HIGH_CYC ((`PSQ_SEL_HIGH_NS * `PSQ_CLK_MHZ + 999) / 1000)
`define PSQ_ACCESS_CYC ((`PSQ_ACCESS_NS * `PSQ_CLK_MHZ + 999) / 1000)
// ----------------------------------------
// command codes
// ----------------------------------------
`define PSQ_CMD_READ 2'h0
`define PSQ_CMD_WRITE 2'h1
`define PSQ_CMD_PDN 2'h2
`define PSQ_CMD_PROG 2'h3
`define PSQ_PROG_CYCLES 3'h6
`endif

//--- logic/psq_timer.v
`timescale 1ns/100ps
// ----------------------------------------
// down counter, done while zero
// ----------------------------------------
module psq_timer #(
  parameter W = 16
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // control
  input wire load,
  input wire [W-1:0] value,
  output wire done
);
  reg [W-1:0] cnt_r;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= {W{1'b0}};
    end else if (load) begin
      cnt_r <= value;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign done = (cnt_r == {W{1'b0}});
endmodule

//--- tb/psq_host_monitor.sv
`timescale 1ns/100ps
module psq_host_monitor #(
  parameter KEEP_LOW_CYC = 20,
  parameter SEL_HIGH_CYC = 40
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // watched pins
  input wire init_done,
  input wire chip_select_n,
  input wire power_keep_enable,
  input wire output_enable_n,
  input wire write_enable_n,
  input wire lower_byte_lane_n,
  input wire upper_byte_lane_n
);
  reg [15:0] low_cnt_r;
  reg [15:0] high_cnt_r;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_r <= 16'h0000;
      high_cnt_r <= 16'h0000;
    end else begin
      low_cnt_r <= power_keep_enable ? 16'h0000 : low_cnt_r + 16'h0001;
      high_cnt_r <= power_keep_enable ? high_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_deselect;
    $rose(chip_select_n);
  endsequence
  sequence s_keep_up;
    $rose(power_keep_enable);
  endsequence
  a_oe_desel_hold: assert property (s_deselect |-> $stable(output_enable_n))
    else $error("output enable moved with deselect");
  a_we_desel_hold: assert property (s_deselect |-> $stable(write_enable_n))
    else $error("write enable moved with deselect");
  a_pwrup_keep_low: assert property (s_keep_up |-> init_done || low_cnt_r >= KEEP_LOW_CYC)
    else $error("keep enable rose too early at power-up");
  a_pdn_keep_low: assert property (s_keep_up |-> low_cnt_r >= 16'h0007)
    else $error("keep enable low pulse too short");
  a_sel_before_init: assert property (!init_done |-> chip_select_n)
    else $error("select low before power-up finished");
  a_init_hold_time: assert property ($rose(init_done) |-> high_cnt_r >= SEL_HIGH_CYC)
    else $error("power-up finished too soon");
  a_lane_on_read: assert property (!chip_select_n && !output_enable_n
    |-> !(lower_byte_lane_n && upper_byte_lane_n))
    else $error("read with no byte lane enabled");
  a_pdn_sel_high: assert property (!power_keep_enable |-> chip_select_n)
    else $error("select low while keep enable low");
endmodule
bind psq_host psq_host_monitor #(.KEEP_LOW_CYC(KEEP_LOW_CYC), .SEL_HIGH_CYC(SEL_HIGH_CYC)) u_mon (
  .core_clk(core_clk), .sys_rst(sys_rst), .init_done(init_done),
  .chip_select_n(chip_select_n), .power_keep_enable(power_keep_enable),
  .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
  .lower_byte_lane_n(lower_byte_lane_n), .upper_byte_lane_n(upper_byte_lane_n));

//--- tb/psq_dev_model.sv
`timescale 1ns/100ps
module psq_dev_model #(
  parameter HAS_PROG = 1
) (
  // memory pins
  input wire chip_select_n,
  input wire power_keep_enable,
  input wire output_enable_n,
  input wire write_enable_n,
  input wire lower_byte_lane_n,
  input wire upper_byte_lane_n,
  input wire [21:0] mem_addr,
  input wire [15:0] mem_dq_o,
  output reg [15:0] mem_dq_i,
  // observation
  output reg hold_viol,
  output reg [21:0] prog_key
);
  logic [15:0] mem [logic [21:0]];
  reg [21:0] wr_addr;
  reg wr_armed = 1'b0;
  reg [2:0] prog_cnt = 3'h0;
  reg [21:0] key_r;
  realtime t_desel = 0.0;
  initial begin
    mem_dq_i = 16'h0000;
    hold_viol = 1'b0;
    prog_key = 22'h000000;
  end
  always @(posedge chip_select_n) t_desel = $realtime;
  always @(output_enable_n or write_enable_n)
    if (chip_select_n && $realtime > 20.0 && $realtime - t_desel < 10.0) hold_viol = 1'b1;
  always @(negedge chip_select_n or negedge write_enable_n) begin
    #1;
    if (!chip_select_n && !write_enable_n) begin
      wr_addr = mem_addr;
      wr_armed = 1'b1;
    end
  end
  always @(posedge chip_select_n or posedge write_enable_n)
    if (wr_armed) begin
      if (!mem.exists(wr_addr)) mem[wr_addr] = 16'h0000;
      if (!lower_byte_lane_n) mem[wr_addr][7:0] = mem_dq_o[7:0];
      if (!upper_byte_lane_n) mem[wr_addr][15:8] = mem_dq_o[15:8];
      wr_armed = 1'b0;
    end
  always @(negedge chip_select_n) begin
    #1;
    if (prog_cnt == 3'h5) begin
      key_r = mem_addr;
      prog_cnt = 3'h6;
    end else prog_cnt = (&mem_addr) ? prog_cnt + 3'h1 : 3'h0;
  end
  always @(posedge chip_select_n)
    if (prog_cnt == 3'h6) begin
      #12;
      if (chip_select_n && HAS_PROG != 0) prog_key = key_r;
      prog_cnt = 3'h0;
    end
  // sleep loses the array and any half-done key
  always @(negedge power_keep_enable) begin
    mem.delete();
    prog_cnt = 3'h0;
  end
  always begin
    #1;
    if (!chip_select_n && !output_enable_n && power_keep_enable)
      mem_dq_i = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
    else mem_dq_i = ~mem_dq_i;
  end
endmodule

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  reg core_clk, sys_rst, cmd_valid;
  reg [1:0] cmd_op, cmd_lanes_n, ln;
  reg [21:0] cmd_addr, key;
  reg [15:0] cmd_wdata, d;
  reg [15:0] exp_mem [0:7];
  reg [2:0] a;
  wire cmd_ready, rsp_valid, init_done, cs_n, pke, oe_n, we_n, lb_n, ub_n, viol, dq_oe;
  wire [15:0] rsp_rdata, dq_o, dq_i;
  wire [21:0] maddr, pkey;
  integer errors, n_checks, cyc, i, n;
  psq_host #(.KEEP_LOW_CYC(20), .SEL_HIGH_CYC(40), .PART_EXIT_CYC(10)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_lanes_n(cmd_lanes_n),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .init_done(init_done), .chip_select_n(cs_n), .power_keep_enable(pke),
    .output_enable_n(oe_n), .write_enable_n(we_n), .lower_byte_lane_n(lb_n),
    .upper_byte_lane_n(ub_n), .mem_addr(maddr), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe),
    .mem_dq_i(dq_i));
  psq_dev_model i_mem (.chip_select_n(cs_n), .power_keep_enable(pke),
    .output_enable_n(oe_n), .write_enable_n(we_n), .lower_byte_lane_n(lb_n),
    .upper_byte_lane_n(ub_n), .mem_addr(maddr), .mem_dq_o(dq_o), .mem_dq_i(dq_i),
    .hold_viol(viol), .prog_key(pkey));
  always #5 core_clk = ~core_clk;
  // ----
  // helpers
  // ----
  function [15:0] merge(input [15:0] old, input [15:0] nw, input [1:0] l);
    merge = {l[1] ? old[15:8] : nw[15:8], l[0] ? old[7:0] : nw[7:0]};
  endfunction
  task end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // request held until taken at a ready edge
  task cmd(input [1:0] op, input [21:0] ad, input [15:0] wd, input [1:0] l);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = ad;
    cmd_wdata = wd;
    cmd_lanes_n = l;
    @(posedge core_clk);
    while (cmd_ready !== 1'b1) @(posedge core_clk);
    #1 cmd_valid = 1'b0;
  endtask
  task rd(input [21:0] ad, input [15:0] exp);
    cmd(2'h0, ad, 16'h0000, 2'b11);
    n = 0;
    @(posedge core_clk);
    while (rsp_valid !== 1'b1 && n < 50) begin
      n = n + 1;
      @(posedge core_clk);
    end
    chk("rsp_valid", rsp_valid, 1);
    chk("rsp_rdata", rsp_rdata, exp);
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      end_sim;
    end
  end
  initial begin
    core_clk = 0; sys_rst = 1; cmd_valid = 0; cmd_op = 0; cmd_addr = 0;
    cmd_wdata = 0; cmd_lanes_n = 0; errors = 0; n_checks = 0; cyc = 0;
    for (i = 0; i < 8; i = i + 1) exp_mem[i] = 16'h0000;
    i = $urandom(32'h06E7);
    repeat (10) @(posedge core_clk);
    chk("select in reset", cs_n, 1);
    chk("keep in reset", pke, 0);
    #1 sys_rst = 0;
    n = 0;
    while (init_done !== 1'b1 && n < 200) begin
      n = n + 1;
      @(posedge core_clk);
    end
    chk("init_done", init_done, 1);
    cmd(2'h1, 22'h3FFFFF, 16'hA5C3, 2'b00);
    chk("mem_dq_oe", dq_oe, 1);
    rd(22'h3FFFFF, 16'hA5C3);
    for (i = 0; i < 24; i = i + 1) begin
      a = $urandom;
      d = $urandom;
      ln = $urandom;
      cmd(2'h1, {19'h0, a}, d, ln);
      exp_mem[a] = merge(exp_mem[a], d, ln);
      a = $urandom;
      rd({19'h0, a}, exp_mem[a]);
    end
    cmd(2'h2, 22'h000000, 16'h0000, 2'b00);
    rd(22'h000003, 16'h0000);
    key = $urandom;
    key[21] = 1'b0;
    cmd(2'h3, key, 16'h0000, 2'b00);
    @(posedge core_clk);
    while (cmd_ready !== 1'b1) @(posedge core_clk);
    chk("prog_key", pkey, key);
    rd(22'h000005, 16'h0000);
    chk("hold_viol", viol, 0);
    end_sim;
  end
endmodule
